//--- verilog/opdec_pkg.sv
/*
  Constants and types for the operand address mode decoder.
  Assumes an 8-bit CPU with a 16-bit address space and opcode maps
  laid out with the mode in the high nibble.
*/
package opdec_pkg;

  typedef enum logic [3:0] {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_DIRECT,
    MODE_EXTENDED,
    MODE_INDEXED_0,
    MODE_INDEXED_8,
    MODE_INDEXED_16,
    MODE_RELATIVE,
    MODE_BIT_BRANCH
  } addr_mode_t;

  typedef enum logic [3:0] {
    OP_SUBTRACT,
    OP_COMPARE_ACC,
    OP_SUBTRACT_WITH_CARRY,
    OP_COMPARE_INDEX,
    OP_AND,
    OP_BIT_TEST,
    OP_LOAD_ACCUMULATOR,
    OP_STORE_ACCUMULATOR,
    OP_EXCLUSIVE_OR_ACC,
    OP_ADD_WITH_CARRY,
    OP_OR_ACCUMULATOR,
    OP_ADD,
    OP_LOAD_INDEX,
    OP_STORE_INDEX,
    OP_MULTIPLY,
    OP_NONE
  } regmem_op_t;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_BYTE1,
    ST_BYTE2,
    ST_DONE
  } fetch_state_t;

  localparam logic [7:0] ZERO_HIGH_BYTE = 8'h00;
  localparam logic [7:0] MULTIPLY_OPCODE = 8'h42;
  localparam logic [3:0] NIBBLE_BIT_BRANCH = 4'h0;
  localparam logic [3:0] NIBBLE_RELATIVE = 4'h2;
  localparam logic [3:0] NIBBLE_IMMEDIATE = 4'hA;
  localparam logic [3:0] NIBBLE_DIRECT = 4'hB;
  localparam logic [3:0] NIBBLE_EXTENDED = 4'hC;
  localparam logic [3:0] NIBBLE_INDEXED_16 = 4'hD;
  localparam logic [3:0] NIBBLE_INDEXED_8 = 4'hE;
  localparam logic [3:0] NIBBLE_INDEXED_0 = 4'hF;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [15:0] PC_RESET = 16'h0000;

endpackage : opdec_pkg

//--- verilog/opdec_mode_table.sv
/*
  Combinational opcode classifier: addressing mode, length and the
  register/memory operation. Assumes opcode is stable while decoded.
*/
`timescale 1ns/1ps
module opdec_mode_table (
  input  wire logic [7:0]          opcode,
  output opdec_pkg::addr_mode_t    mode,
  output logic [1:0]               length,
  output opdec_pkg::regmem_op_t    op,
  output logic                     is_branch
);

  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    mode      = opdec_pkg::MODE_INHERENT;
    length    = opdec_pkg::LEN_ONE;
    is_branch = 1'b0;
    case (hi)
      opdec_pkg::NIBBLE_BIT_BRANCH: begin
        mode      = opdec_pkg::MODE_BIT_BRANCH;
        length    = opdec_pkg::LEN_THREE;
        is_branch = 1'b1;
      end
      opdec_pkg::NIBBLE_RELATIVE: begin
        mode      = opdec_pkg::MODE_RELATIVE;
        length    = opdec_pkg::LEN_TWO;
        is_branch = 1'b1;
      end
      opdec_pkg::NIBBLE_IMMEDIATE: begin
        mode   = opdec_pkg::MODE_IMMEDIATE;
        length = opdec_pkg::LEN_TWO;
      end
      opdec_pkg::NIBBLE_DIRECT: begin
        mode   = opdec_pkg::MODE_DIRECT;
        length = opdec_pkg::LEN_TWO;
      end
      opdec_pkg::NIBBLE_EXTENDED: begin
        mode   = opdec_pkg::MODE_EXTENDED;
        length = opdec_pkg::LEN_THREE;
      end
      opdec_pkg::NIBBLE_INDEXED_16: begin
        mode   = opdec_pkg::MODE_INDEXED_16;
        length = opdec_pkg::LEN_THREE;
      end
      opdec_pkg::NIBBLE_INDEXED_8: begin
        mode   = opdec_pkg::MODE_INDEXED_8;
        length = opdec_pkg::LEN_TWO;
      end
      opdec_pkg::NIBBLE_INDEXED_0: begin
        mode   = opdec_pkg::MODE_INDEXED_0;
        length = opdec_pkg::LEN_ONE;
      end
      default: begin
        mode      = opdec_pkg::MODE_INHERENT;
        length    = opdec_pkg::LEN_ONE;
        is_branch = 1'b0;
      end
    endcase
  end

  always_comb begin
    op = opdec_pkg::OP_NONE;
    if (opcode == opdec_pkg::MULTIPLY_OPCODE) begin
      op = opdec_pkg::OP_MULTIPLY;
    end else if (hi >= opdec_pkg::NIBBLE_IMMEDIATE) begin
      case (lo)
        4'h0: op = opdec_pkg::OP_SUBTRACT;
        4'h1: op = opdec_pkg::OP_COMPARE_ACC;
        4'h2: op = opdec_pkg::OP_SUBTRACT_WITH_CARRY;
        4'h3: op = opdec_pkg::OP_COMPARE_INDEX;
        4'h4: op = opdec_pkg::OP_AND;
        4'h5: op = opdec_pkg::OP_BIT_TEST;
        4'h6: op = opdec_pkg::OP_LOAD_ACCUMULATOR;
        4'h7: op = opdec_pkg::OP_STORE_ACCUMULATOR;
        4'h8: op = opdec_pkg::OP_EXCLUSIVE_OR_ACC;
        4'h9: op = opdec_pkg::OP_ADD_WITH_CARRY;
        4'hA: op = opdec_pkg::OP_OR_ACCUMULATOR;
        4'hB: op = opdec_pkg::OP_ADD;
        4'hE: op = opdec_pkg::OP_LOAD_INDEX;
        4'hF: op = opdec_pkg::OP_STORE_INDEX;
        default: op = opdec_pkg::OP_NONE;
      endcase
    end
  end

endmodule : opdec_mode_table

//--- verilog/operand_address_mode_decoder.sv
/*
  Instruction length and operand effective address generation.
  Assumes a synchronous memory that returns MEM_RDATA one cycle after
  MEM_RD is raised at MEM_ADDR, and a core that supplies the index
  register and the branch condition.
*/
`timescale 1ns/1ps
// How it works
// - Inherent opcodes are one byte and produce no operand address.
// - Immediate opcodes are two bytes; second byte is the literal.
// - Direct opcodes are two bytes; address high byte is zero.
// - Bit test branches are three bytes: direct operand, relative target.
// - Extended opcodes are three bytes; address taken high then low.
// - Indexed no offset is one byte; address is zero then index.
// - Indexed 8-bit offset is two bytes; index plus offset, unsigned.
// - Indexed 16-bit offset is three bytes; index plus 16-bit offset.
// - Taken branch adds signed offset to the next instruction address.
// - Untaken branch continues at the next instruction.
// - Relative mode applies only to branch opcodes.
// - Register/memory ops take a memory operand only in modes that give an operand address.
// - Register/memory group holds the fifteen listed operations.
module operand_address_mode_decoder (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic [7:0]  INDEX_REG,
  input  wire logic        BRANCH_COND,
  output logic             MEM_RD,
  output logic [15:0]      MEM_ADDR,
  output logic             DONE,
  output logic [7:0]       OPCODE,
  output logic [1:0]       INSN_LENGTH,
  output logic [3:0]       ADDR_MODE,
  output logic [3:0]       REGMEM_OP,
  output logic             REGMEM_USES_MEM,
  output logic             ADDR_VALID,
  output logic [15:0]      OPERAND_ADDR,
  output logic [7:0]       IMMEDIATE_DATA,
  output logic             IMMEDIATE_VALID,
  output logic [15:0]      NEXT_PC,
  output logic [15:0]      PC
);

  opdec_pkg::fetch_state_t state_q;
  opdec_pkg::addr_mode_t   mode;
  opdec_pkg::regmem_op_t   op;
  logic [1:0]              length;
  logic                    is_branch;
  logic [7:0]              opcode_q;
  logic [7:0]              byte1_q;
  logic [15:0]             pc_q;
  logic [15:0]             fetch_pc_q;
  logic [15:0]             next_pc;
  logic [15:0]             operand_addr_d;
  logic                    addr_valid_d;
  logic [15:0]             branch_target;
  logic [15:0]             rel_offset;
  logic [15:0]             offset16;
  logic [15:0]             index16;
  logic [7:0]              opcode_now;
  logic [15:0]             operand_addr_q;
  logic                    addr_valid_q;
  logic [7:0]              imm_q;
  logic                    imm_valid_q;
  logic                    done_q;
  logic [15:0]             next_pc_q;

  // Opcode byte arrives in ST_BYTE1's first cycle on MEM_RDATA
  assign opcode_now = (state_q == opdec_pkg::ST_BYTE1) ? MEM_RDATA
                                                        : opcode_q;

  opdec_mode_table u_table (
    .opcode    (opcode_now),
    .mode      (mode),
    .length    (length),
    .op        (op),
    .is_branch (is_branch)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= opdec_pkg::ST_OPCODE;
    end else begin
      case (state_q)
        opdec_pkg::ST_OPCODE: begin
          if (START) begin
            state_q <= opdec_pkg::ST_BYTE1;
          end
        end
        opdec_pkg::ST_BYTE1: begin
          if (length == opdec_pkg::LEN_ONE) begin
            state_q <= opdec_pkg::ST_DONE;
          end else begin
            state_q <= opdec_pkg::ST_BYTE2;
          end
        end
        opdec_pkg::ST_BYTE2: begin
          if (length == opdec_pkg::LEN_TWO) begin
            state_q <= opdec_pkg::ST_DONE;
          end else begin
            state_q <= opdec_pkg::ST_DONE;
          end
        end
        opdec_pkg::ST_DONE: begin
          state_q <= opdec_pkg::ST_OPCODE;
        end
        default: begin
          state_q <= opdec_pkg::ST_OPCODE;
        end
      endcase
    end
  end

  // Byte counter: three-byte forms read their last byte in ST_DONE
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      opcode_q   <= 8'h00;
      byte1_q    <= 8'h00;
      fetch_pc_q <= opdec_pkg::PC_RESET;
    end else begin
      case (state_q)
        opdec_pkg::ST_OPCODE: begin
          if (START) begin
            fetch_pc_q <= pc_q + 16'h0001;
          end
        end
        opdec_pkg::ST_BYTE1: begin
          opcode_q <= MEM_RDATA;
          if (length != opdec_pkg::LEN_ONE) begin
            fetch_pc_q <= fetch_pc_q + 16'h0001;
          end
        end
        opdec_pkg::ST_BYTE2: begin
          byte1_q <= MEM_RDATA;
          if (length == opdec_pkg::LEN_THREE) begin
            fetch_pc_q <= fetch_pc_q + 16'h0001;
          end
        end
        default: begin
          fetch_pc_q <= fetch_pc_q;
        end
      endcase
    end
  end

  // Memory read strobe and address for each fetched byte
  always_comb begin
    MEM_RD   = 1'b0;
    MEM_ADDR = fetch_pc_q;
    case (state_q)
      opdec_pkg::ST_OPCODE: begin
        MEM_RD   = START;
        MEM_ADDR = pc_q;
      end
      opdec_pkg::ST_BYTE1: begin
        MEM_RD = (length != opdec_pkg::LEN_ONE);
      end
      opdec_pkg::ST_BYTE2: begin
        MEM_RD = (length == opdec_pkg::LEN_THREE);
      end
      default: begin
        MEM_RD = 1'b0;
      end
    endcase
  end

  // Final byte: opcode in ST_BYTE1 for one-byte forms, byte1 in ST_BYTE2 for two-byte, else ST_DONE
  logic        last_cycle;
  logic [7:0]  b1;
  logic [7:0]  b2;

  always_comb begin
    last_cycle = 1'b0;
    b1 = byte1_q;
    b2 = MEM_RDATA;
    case (state_q)
      opdec_pkg::ST_BYTE1: begin
        last_cycle = (length == opdec_pkg::LEN_ONE);
      end
      opdec_pkg::ST_BYTE2: begin
        last_cycle = (length == opdec_pkg::LEN_TWO);
        b1 = MEM_RDATA;
      end
      opdec_pkg::ST_DONE: begin
        last_cycle = (length == opdec_pkg::LEN_THREE);
      end
      default: begin
        last_cycle = 1'b0;
      end
    endcase
  end

  // Next instruction address: opcode address plus length
  assign next_pc = pc_q + {14'h0000, length};
  assign index16 = {opdec_pkg::ZERO_HIGH_BYTE, INDEX_REG};
  assign offset16 = {b1, b2};
  assign rel_offset = {{8{b2[7]}}, b2};
  assign branch_target = next_pc + rel_offset;

  always_comb begin
    operand_addr_d = 16'h0000;
    addr_valid_d   = 1'b0;
    case (mode)
      opdec_pkg::MODE_DIRECT: begin
        operand_addr_d = {opdec_pkg::ZERO_HIGH_BYTE, b1};
        addr_valid_d   = 1'b1;
      end
      opdec_pkg::MODE_BIT_BRANCH: begin
        operand_addr_d = {opdec_pkg::ZERO_HIGH_BYTE, b1};
        addr_valid_d   = 1'b1;
      end
      opdec_pkg::MODE_EXTENDED: begin
        operand_addr_d = offset16;
        addr_valid_d   = 1'b1;
      end
      opdec_pkg::MODE_INDEXED_0: begin
        operand_addr_d = index16;
        addr_valid_d   = 1'b1;
      end
      opdec_pkg::MODE_INDEXED_8: begin
        operand_addr_d = index16 + {opdec_pkg::ZERO_HIGH_BYTE, b2};
        addr_valid_d   = 1'b1;
      end
      opdec_pkg::MODE_INDEXED_16: begin
        operand_addr_d = offset16 + index16;
        addr_valid_d   = 1'b1;
      end
      default: begin
        operand_addr_d = 16'h0000;
        addr_valid_d   = 1'b0;
      end
    endcase
  end

  // Short forms carry their single operand byte in b2
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      operand_addr_q <= 16'h0000;
      addr_valid_q   <= 1'b0;
      imm_q          <= 8'h00;
      imm_valid_q    <= 1'b0;
      done_q         <= 1'b0;
      next_pc_q      <= opdec_pkg::PC_RESET;
    end else begin
      done_q <= last_cycle;
      if (last_cycle) begin
        operand_addr_q <= operand_addr_d;
        addr_valid_q   <= addr_valid_d;
        imm_valid_q    <= (mode == opdec_pkg::MODE_IMMEDIATE);
        imm_q          <= (mode == opdec_pkg::MODE_IMMEDIATE) ? b1
                                                              : 8'h00;
        next_pc_q      <= next_pc;
      end
    end
  end

  // Program counter advance at the end of each instruction
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pc_q <= opdec_pkg::PC_RESET;
    end else if (last_cycle) begin
      if (is_branch && BRANCH_COND) begin
        pc_q <= branch_target;
      end else begin
        pc_q <= next_pc;
      end
    end
  end

  assign DONE            = done_q;
  assign OPCODE          = opcode_q;
  assign ADDR_MODE       = 4'(mode);
  assign REGMEM_OP       = 4'(op);
  assign REGMEM_USES_MEM = addr_valid_q && (op != opdec_pkg::OP_NONE);
  assign ADDR_VALID      = addr_valid_q;
  assign OPERAND_ADDR    = operand_addr_q;
  assign IMMEDIATE_DATA  = imm_q;
  assign IMMEDIATE_VALID = imm_valid_q;
  assign NEXT_PC         = next_pc_q;
  assign PC              = pc_q;
  assign INSN_LENGTH     = length;

endmodule : operand_address_mode_decoder

//--- verification/opdec_properties.sv
/*
  Concurrent checks on the decoder's top-level ports.
  Assumes INDEX_REG and BRANCH_COND are held through each fetch.
*/
`timescale 1ns/1ps
module opdec_properties (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        DONE,
  input wire logic        MEM_RD,
  input wire logic        BRANCH_COND,
  input wire logic        ADDR_VALID,
  input wire logic        IMMEDIATE_VALID,
  input wire logic [7:0]  MEM_RDATA,
  input wire logic [7:0]  INDEX_REG,
  input wire logic [7:0]  IMMEDIATE_DATA,
  input wire logic [3:0]  ADDR_MODE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] OPERAND_ADDR,
  input wire logic [15:0] NEXT_PC,
  input wire logic [15:0] PC
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_done_single: assert property (DONE |=> !DONE)
    else $error("done held longer than one cycle");
  a_fetch_step: assert property (MEM_RD && $past(MEM_RD) && !DONE
    |-> MEM_ADDR == $past(MEM_ADDR) + 16'h0001)
    else $error("fetch address did not step by one");
  a_no_operand: assert property (DONE && (ADDR_MODE == 4'h0
    || ADDR_MODE == 4'h1) |-> !ADDR_VALID)
    else $error("operand address flagged without memory operand");
  a_direct_page: assert property (DONE && ADDR_MODE == 4'h2
    |-> OPERAND_ADDR == {8'h00, $past(MEM_RDATA)} && ADDR_VALID)
    else $error("direct address wrong");
  a_bitbr_page: assert property (DONE && ADDR_MODE == 4'h8
    |-> OPERAND_ADDR == {8'h00, $past(MEM_RDATA, 2)} && ADDR_VALID)
    else $error("bit branch operand address wrong");
  a_rel_noaddr: assert property (DONE && ADDR_MODE == 4'h7
    |-> !ADDR_VALID)
    else $error("relative branch flagged an operand address");
  a_ix0_addr: assert property (DONE && ADDR_MODE == 4'h4
    |-> OPERAND_ADDR == {8'h00, INDEX_REG} && ADDR_VALID)
    else $error("indexed no-offset address wrong");
  a_ix8_sum: assert property (DONE && ADDR_MODE == 4'h5
    |-> OPERAND_ADDR == 16'(INDEX_REG) + 16'($past(MEM_RDATA)))
    else $error("indexed 8-bit offset address wrong");
  a_ext_addr: assert property (DONE && ADDR_MODE == 4'h3
    |-> OPERAND_ADDR == {$past(MEM_RDATA, 2), $past(MEM_RDATA)})
    else $error("extended address wrong");
  a_ix16_sum: assert property (DONE && ADDR_MODE == 4'h6
    |-> OPERAND_ADDR == {$past(MEM_RDATA, 2), $past(MEM_RDATA)}
    + 16'(INDEX_REG))
    else $error("indexed 16-bit offset address wrong");
  a_imm_literal: assert property (DONE && ADDR_MODE == 4'h1
    |-> IMMEDIATE_VALID && IMMEDIATE_DATA == $past(MEM_RDATA))
    else $error("immediate literal wrong");
  a_untaken_next: assert property (DONE && !$past(BRANCH_COND)
    |-> PC == NEXT_PC)
    else $error("program counter moved without a taken branch");
  a_rel_taken: assert property (DONE && ADDR_MODE == 4'h7
    && $past(BRANCH_COND) |-> PC == NEXT_PC
    + {{8{$past(MEM_RDATA[7])}}, $past(MEM_RDATA)})
    else $error("relative branch target wrong");

  c_ext_done: cover property (DONE && ADDR_MODE == 4'h3);
  c_rel_taken: cover property (DONE && ADDR_MODE == 4'h7 && PC != NEXT_PC);
  c_ix8_carry: cover property (DONE && ADDR_MODE == 4'h5
    && OPERAND_ADDR[8]);
endmodule : opdec_properties

bind operand_address_mode_decoder opdec_properties u_props (
  .CORE_CLK(CORE_CLK), .RST(RST), .DONE(DONE), .MEM_RD(MEM_RD),
  .BRANCH_COND(BRANCH_COND), .ADDR_VALID(ADDR_VALID),
  .IMMEDIATE_VALID(IMMEDIATE_VALID), .MEM_RDATA(MEM_RDATA),
  .INDEX_REG(INDEX_REG), .IMMEDIATE_DATA(IMMEDIATE_DATA),
  .ADDR_MODE(ADDR_MODE), .MEM_ADDR(MEM_ADDR),
  .OPERAND_ADDR(OPERAND_ADDR), .NEXT_PC(NEXT_PC), .PC(PC));

//--- verification/opdec_memory_model.sv
/*
  Byte-wide synchronous code memory for the decoder.
  Assumes one read strobe per byte; bench fills mem_q directly.
*/
`timescale 1ns/1ps
module opdec_memory_model (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  output logic      [7:0]  rdata
);
  logic [7:0] mem_q [65536];
  initial rdata = 8'h00;
  // Idle bus toggles so stale bytes are never mistaken for data
  always @(posedge clk) begin
    if (rd) begin
      rdata <= mem_q[addr];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : opdec_memory_model

//--- verification/tb_operand_address_mode_decoder.sv
/*
  Self-checking bench: directed and random instructions against a
  reference model. Assumes the memory model answers one cycle late.
*/
`timescale 1ns/1ps
module tb_operand_address_mode_decoder;
  logic core_clk = 1'b0, rst = 1'b1, start = 1'b0, cond = 1'b0;
  logic [7:0] idx = 8'h00, rdata, opc, imm_d;
  logic rd, done, uses, av, iv;
  logic [15:0] maddr, oaddr, npc, pc;
  logic [1:0] ilen;
  logic [3:0] mode, rop;
  logic [15:0] pc_m = 16'h0000;
  int num_errors = 0, compares = 0;
  integer seed = 32'hc739c63c;
  logic [39:0] dirs [13] = '{40'hE0FF00FF00, 40'hD5FFFF0100,
    40'hDB12F02000, 40'h2080000001, 40'h207F000001, 40'h2005000000,
    40'h0134FE0001, 40'h4200000000, 40'h9D00000000, 40'hA655000000,
    40'hB680000000, 40'hCC12340000, 40'hF00000FF00};
  logic [3:0] nibs [10] = '{4'h0, 4'h2, 4'h4, 4'h9, 4'hA, 4'hB,
    4'hC, 4'hD, 4'hE, 4'hF};

  always #20 core_clk = ~core_clk;

  operand_address_mode_decoder DUT (.CORE_CLK(core_clk), .RST(rst),
    .START(start), .MEM_RDATA(rdata), .INDEX_REG(idx),
    .BRANCH_COND(cond), .MEM_RD(rd), .MEM_ADDR(maddr), .DONE(done),
    .OPCODE(opc), .INSN_LENGTH(ilen), .ADDR_MODE(mode),
    .REGMEM_OP(rop), .REGMEM_USES_MEM(uses), .ADDR_VALID(av),
    .OPERAND_ADDR(oaddr), .IMMEDIATE_DATA(imm_d),
    .IMMEDIATE_VALID(iv), .NEXT_PC(npc), .PC(pc));

  opdec_memory_model mem_model (.clk(core_clk), .rd(rd),
    .addr(maddr), .rdata(rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic run_insn(input logic [7:0] op, input logic [7:0] b1,
                          input logic [7:0] b2, input logic [7:0] x,
                          input logic c);
    int len, n;
    logic [3:0] md, eop;
    logic [15:0] ea, nx, np;
    logic [7:0] off;
    logic ev, br;
    case (op[7:4])
      4'h0: begin md = 4'h8; len = 3; end
      4'h2: begin md = 4'h7; len = 2; end
      4'hA: begin md = 4'h1; len = 2; end
      4'hB: begin md = 4'h2; len = 2; end
      4'hC: begin md = 4'h3; len = 3; end
      4'hD: begin md = 4'h6; len = 3; end
      4'hE: begin md = 4'h5; len = 2; end
      4'hF: begin md = 4'h4; len = 1; end
      default: begin md = 4'h0; len = 1; end
    endcase
    case (md)
      4'h2, 4'h8: ea = {8'h00, b1};
      4'h3: ea = {b1, b2};
      4'h4: ea = {8'h00, x};
      4'h5: ea = 16'(x) + 16'(b1);
      4'h6: ea = {b1, b2} + 16'(x);
      default: ea = 16'h0000;
    endcase
    ev = md inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    // Low nibble C and D unused; E and F are index load and store
    eop = (op == 8'h42) ? 4'hE : 4'hF;
    if (op[7:4] >= 4'hA) begin
      case (op[3:0])
        4'hC, 4'hD: eop = 4'hF;
        4'hE, 4'hF: eop = op[3:0] - 4'h2;
        default: eop = op[3:0];
      endcase
    end
    nx = pc_m + 16'(len);
    off = (md == 4'h8) ? b2 : b1;
    br = (md == 4'h7 || md == 4'h8) && c;
    np = br ? nx + {{8{off[7]}}, off} : nx;
    mem_model.mem_q[pc_m] = op;
    mem_model.mem_q[pc_m + 16'h1] = b1;
    mem_model.mem_q[pc_m + 16'h2] = b2;
    @(posedge core_clk);
    start <= 1'b1;
    idx <= x;
    cond <= c;
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      #1;
    end while (done !== 1'b1 && n < 8);
    chk(16'(n), 16'(len));
    chk(16'(ilen), 16'(len));
    chk(npc, nx);
    chk(16'(mode), 16'(md));
    chk(16'(opc), 16'(op));
    chk(16'(rop), 16'(eop));
    chk(16'(uses), 16'(eop != 4'hF && ev));
    chk(16'(av), 16'(ev));
    if (ev) chk(oaddr, ea);
    chk(16'(iv), 16'(md == 4'h1));
    chk(16'(imm_d), (md == 4'h1) ? 16'(b1) : 16'h0000);
    chk(pc, np);
    pc_m = np;
    @(posedge core_clk);
  endtask : run_insn

  task automatic test_done;
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    #(40 * 10000);
    num_errors++;
    test_done;
  end

  initial begin
    logic [31:0] r;
    logic [7:0] op;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(pc, 16'h0000);
    chk(16'(done), 16'h0000);
    foreach (dirs[i])
      run_insn(dirs[i][39:32], dirs[i][31:24], dirs[i][23:16],
               dirs[i][15:8], dirs[i][0]);
    // Reset in mid-fetch returns to the start vector
    mem_model.mem_q[pc_m] = 8'hCC;
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    pc_m = 16'h0000;
    #1 chk(pc, 16'h0000);
    chk(npc, 16'h0000);
    chk(16'(av), 16'h0000);
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      op = {nibs[r[31:16] % 10], r[15:12]};
      if (op[7:4] == 4'hA && (op[3:0] == 4'h7 || op[3:0] == 4'hD))
        op[3:0] = 4'h0;
      r = $random(seed);
      run_insn(op, r[7:0], r[15:8], r[23:16], r[24]);
    end
    test_done;
  end
endmodule : tb_operand_address_mode_decoder
